// ===== design/chained_pwm_pulse_timers.sv
/*
 * three chained pwm / pulse timers with their control and duty registers;
 * assumes a same-clock register port and drivers that take the waves.
 */
`timescale 1ns/1ps
`default_nettype none
`include "timer_map.svh"

module chained_pwm_pulse_timers
	import timer_pkg::*;
#(
	parameter int TICK_CYCLES = `TICK_CYCLES
)(
	input  wire logic     clock_in,
	input  wire logic     rst_in,
	input  wire reg_req_t req_in,
	output logic [7:0]    rdata_out,
	output logic          rvalid_out,
	output logic [2:0]    high_voltage_io_out
);

	// period code to base ticks; unknown codes take the longest
	function automatic logic [15:0] period_ticks(input logic [3:0] code);
		case (code)
			4'h0:    period_ticks = 16'd40;
			4'h1:    period_ticks = 16'd80;
			4'h2:    period_ticks = 16'd200;
			4'h3:    period_ticks = 16'd300;
			4'h4:    period_ticks = 16'd500;
			4'h5:    period_ticks = 16'd1000;
			4'h6:    period_ticks = 16'd2000;
			4'h7:    period_ticks = 16'd4000;
			4'h8:    period_ticks = 16'd8000;
			4'h9:    period_ticks = 16'd10000;
			4'ha:    period_ticks = 16'd20000;
			default: period_ticks = 16'd40000;
		endcase
	endfunction

	// stored control bits as seen on a read; reserved top bits read zero
	function automatic logic [7:0] ctrl_image(input logic [5:0] ctrl);
		ctrl_image = {2'h0, ctrl};
	endfunction

	logic [5:0]  master_ctrl_ff;
	logic [7:0]  master_duty_ff;
	logic [5:0]  second_ctrl_ff;
	logic [7:0]  second_duty_ff;
	logic [5:0]  third_ctrl_ff;
	logic [7:0]  third_duty_ff;
	logic [15:0] tick_cnt_ff;
	logic        tick_ff;
	logic [7:0]  nxt_rdata;
	logic        wr_master_ctrl;
	logic        wr_master_duty;
	logic        wr_second_ctrl;
	logic        wr_second_duty;
	logic        wr_third_ctrl;
	logic        wr_third_duty;
	chain_t      master_chain;
	chain_t      second_chain;
	chain_t      third_chain;
	logic [2:0]  waves;
	timer_mode_t master_mode;
	timer_mode_t second_mode;
	timer_mode_t third_mode;
	logic        second_trig;
	logic        third_trig;
	logic [15:0] third_up_period;
	logic [15:0] master_period;
	logic [15:0] second_period;
	logic [15:0] third_period;

	// write decode
	assign wr_master_ctrl = req_in.wr && req_in.addr == `MASTER_CTRL_OFS;
	assign wr_master_duty = req_in.wr && req_in.addr == `MASTER_DUTY_OFS;
	assign wr_second_ctrl = req_in.wr && req_in.addr == `SECOND_CTRL_OFS;
	assign wr_second_duty = req_in.wr && req_in.addr == `SECOND_DUTY_OFS;
	assign wr_third_ctrl  = req_in.wr && req_in.addr == `THIRD_CTRL_OFS;
	assign wr_third_duty  = req_in.wr && req_in.addr == `THIRD_DUTY_OFS;

	// register file; reserved bits are not stored
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			master_ctrl_ff <= 6'(`CTRL_RESET);
			master_duty_ff <= `DUTY_RESET;
			second_ctrl_ff <= 6'(`CTRL_RESET);
			second_duty_ff <= `DUTY_RESET;
			third_ctrl_ff  <= 6'(`CTRL_RESET);
			third_duty_ff  <= `DUTY_RESET;
		end else begin
			if (wr_master_ctrl) master_ctrl_ff <= {req_in.wdata[5:2], 1'b0, req_in.wdata[0]};
			if (wr_master_duty) master_duty_ff <= req_in.wdata;
			if (wr_second_ctrl) second_ctrl_ff <= req_in.wdata[5:0];
			if (wr_second_duty) second_duty_ff <= req_in.wdata;
			if (wr_third_ctrl)  third_ctrl_ff  <= req_in.wdata[5:0];
			if (wr_third_duty)  third_duty_ff  <= req_in.wdata;
		end
	end

	// read mux; reserved bits and unmapped offsets read zero
	always_comb begin
		case (req_in.addr)
			`MASTER_CTRL_OFS: nxt_rdata = ctrl_image(master_ctrl_ff);
			`MASTER_DUTY_OFS: nxt_rdata = master_duty_ff;
			`SECOND_CTRL_OFS: nxt_rdata = ctrl_image(second_ctrl_ff);
			`SECOND_DUTY_OFS: nxt_rdata = second_duty_ff;
			`THIRD_CTRL_OFS:  nxt_rdata = ctrl_image(third_ctrl_ff);
			`THIRD_DUTY_OFS:  nxt_rdata = third_duty_ff;
			default:          nxt_rdata = 8'h00;
		endcase
	end

	// read answer one cycle after the request
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			rdata_out  <= 8'h00;
			rvalid_out <= 1'b0;
		end else begin
			rdata_out  <= req_in.rd ? nxt_rdata : 8'h00;
			rvalid_out <= req_in.rd;
		end
	end

	// shared 100 us time base for all channels
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			tick_cnt_ff <= 16'h0000;
			tick_ff     <= 1'b0;
		end else begin
			tick_ff     <= tick_cnt_ff == 16'(TICK_CYCLES - 1);
			tick_cnt_ff <= (tick_cnt_ff == 16'(TICK_CYCLES - 1)) ? 16'h0000 : tick_cnt_ff + 16'h0001;
		end
	end

	// modes; master has only the two autonomous choices
	assign master_mode = timer_mode_t'({1'b0, master_ctrl_ff[`MODE_LSB]});
	assign second_mode = timer_mode_t'(second_ctrl_ff[`MODE_MSB:`MODE_LSB]);
	assign third_mode  = timer_mode_t'(third_ctrl_ff[`MODE_MSB:`MODE_LSB]);

	// own periods of each channel, decoded from the period code field
	assign master_period = period_ticks(master_ctrl_ff[`PERIOD_SEL_MSB:`PERIOD_SEL_LSB]);
	assign second_period = period_ticks(second_ctrl_ff[`PERIOD_SEL_MSB:`PERIOD_SEL_LSB]);
	assign third_period  = period_ticks(third_ctrl_ff[`PERIOD_SEL_MSB:`PERIOD_SEL_LSB]);

	// chain triggers
	// every trigger is born on a tick edge, so the slaves count in step
	// with the timer above; a slave keeps running after its first trigger
	// even when the upstream duty is zero, since start still pulses then
	assign second_trig = (second_mode == mode_sync) ? master_chain.start : master_chain.stop;
	assign third_trig  = (third_mode == mode_sync) ? master_chain.start : second_chain.stop;
	assign third_up_period = (third_mode == mode_sync) ? master_chain.period : second_chain.period;

	pwm_channel u_master (
		.clock_in      (clock_in),
		.rst_in        (rst_in),
		.tick_in       (tick_ff),
		.mode_in       (master_mode),
		.own_period_in (master_period),
		.duty_in       (master_duty_ff),
		.trig_in       (1'b0),
		.up_period_in  (16'h0000),
		.chain_out     (master_chain),
		.wave_out      (waves[0])
	);

	pwm_channel u_second (
		.clock_in      (clock_in),
		.rst_in        (rst_in),
		.tick_in       (tick_ff),
		.mode_in       (second_mode),
		.own_period_in (second_period),
		.duty_in       (second_duty_ff),
		.trig_in       (second_trig),
		.up_period_in  (master_chain.period),
		.chain_out     (second_chain),
		.wave_out      (waves[1])
	);

	pwm_channel u_third (
		.clock_in      (clock_in),
		.rst_in        (rst_in),
		.tick_in       (tick_ff),
		.mode_in       (third_mode),
		.own_period_in (third_period),
		.duty_in       (third_duty_ff),
		.trig_in       (third_trig),
		.up_period_in  (third_up_period),
		.chain_out     (third_chain),
		.wave_out      (waves[2])
	);

	// waves pass one output flop so every top output leaves a local register;
	// the extra cycle is the same on all three, so chain phases are kept
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			high_voltage_io_out <= 3'h0;
		end else begin
			high_voltage_io_out <= waves;
		end
	end

endmodule // chained_pwm_pulse_timers

`default_nettype wire

// ===== design/timer_map.svh
/*
 * register offsets, field positions, reset values and timing counts of the
 * chained pwm / pulse timers; assumes inclusion by bare name from design files.
 */
//
// Contract
// - master control: period select bits 5:2, mode bit 0, bits 7,6,1 reserved read-only
// - period codes 0..11 give 4,8,20,30,50,100,200,400,800 ms, 1,2,4 s
// - second/third control: period select bits 5:2, two-bit mode bits 1:0, 7:6 reserved
// - master mode 0 is pwm, on-time equals duty times period over 255
// - master mode 1 gives duty times base unit pulse at selected period
// - every timer has eight-bit read-write duty register; master duty at 51h
// - second duty at 53h, third control at 54h after master pair
// - slave-capable timers: mode 00 pwm, mode 01 pulse at selected period
// - second timer mode 10 starts its pulse at master pulse start
// - second timer mode 11 starts its pulse at master pulse end
// - third timer mode 10 starts its pulse at master pulse start
// - third timer mode 11 starts its pulse at second timer pulse end
// - base unit 100 us; on-time beyond period keeps output on
// - autonomous pulse mode holds output off for the first full period; code keeps it off until one tick after the first counter wrap
// - slave ignores own period select, inherits period up the chain
// - slaves still triggered when master duty is zero
`ifndef TIMER_MAP_SVH
`define TIMER_MAP_SVH

`define MASTER_CTRL_OFS     7'h50
`define MASTER_DUTY_OFS     7'h51
`define SECOND_CTRL_OFS     7'h52
`define SECOND_DUTY_OFS     7'h53
`define THIRD_CTRL_OFS      7'h54
`define THIRD_DUTY_OFS      7'h55

`define PERIOD_SEL_MSB      5
`define PERIOD_SEL_LSB      2
`define MODE_MSB            1
`define MODE_LSB            0

`define CTRL_RESET          8'h00
`define DUTY_RESET          8'h00

`define CLK_MHZ             125
`define BASE_UNIT_US        100
`define TICK_CYCLES         (`BASE_UNIT_US * `CLK_MHZ)
`define DUTY_FULL_SCALE     8'hff
`define LAST_PERIOD_CODE    4'hb

`endif

// ===== design/timer_pkg.sv
/*
 * types shared by the chained timers; assumes timer_map.svh for the numbers.
 */
package timer_pkg;

	// timer operating mode as held in the control register
	typedef enum logic [1:0] {
		mode_pwm      = 2'h0,
		mode_pulse    = 2'h1,
		mode_sync     = 2'h2,
		mode_follower = 2'h3
	} timer_mode_t;

	// one register access from the programming port
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [6:0] addr;
		logic [7:0] wdata;
	} reg_req_t;

	// events a timer offers to the next in the chain
	typedef struct packed {
		logic        start;
		logic        stop;
		logic [15:0] period;
	} chain_t;

endpackage

// ===== design/pwm_channel.sv
/*
 * one pwm / pulse timer channel; assumes a one-cycle base tick shared with
 * the other channels and a trigger aligned to that tick.
 */
`timescale 1ns/1ps
`default_nettype none
`include "timer_map.svh"

module pwm_channel
	import timer_pkg::*;
(
	input  wire logic        clock_in,
	input  wire logic        rst_in,
	input  wire logic        tick_in,
	input  wire timer_mode_t mode_in,
	input  wire logic [15:0] own_period_in,
	input  wire logic [7:0]  duty_in,
	input  wire logic        trig_in,
	input  wire logic [15:0] up_period_in,
	output chain_t           chain_out,
	output logic             wave_out
);

	logic [15:0] cnt_ff;
	logic [15:0] nxt_cnt;
	logic        first_ff;
	logic        running_ff;
	logic        wave_ff;
	logic        nxt_wave;
	logic        wave_step;
	logic        chain_start;
	logic        slave;
	logic        wrap;
	logic [15:0] period;
	logic [23:0] pwm_lhs;
	logic [23:0] pwm_rhs;

	// slaves take the period of the timer above them
	assign slave  = mode_in[1];
	assign period = slave ? up_period_in : own_period_in;
	assign wrap   = tick_in && !slave && (cnt_ff >= period - 16'h0001);

	// next count: restart on wrap or trigger, else step on tick
	assign nxt_cnt = (slave && trig_in) || wrap ? 16'h0000 :
		(tick_in && cnt_ff != 16'hffff) ? cnt_ff + 16'h0001 : cnt_ff;

	// pwm compare: cnt*255 < duty*period
	assign pwm_lhs = 24'(nxt_cnt) * 24'(`DUTY_FULL_SCALE);
	assign pwm_rhs = 24'(duty_in) * 24'(period);

	// waveform of the coming cycle
	always_comb begin
		case (mode_in)
			mode_pwm:   nxt_wave = pwm_lhs < pwm_rhs;
			mode_pulse: nxt_wave = !(first_ff || (wrap && first_ff)) &&
				(nxt_cnt < 16'(duty_in) || 16'(duty_in) >= period);
			default:    nxt_wave = (running_ff || trig_in) &&
				(nxt_cnt < 16'(duty_in) || 16'(duty_in) >= period);
		endcase
	end

	// wave moves only on a tick, so register writes never cut a pulse off-grid
	assign wave_step = tick_in ? nxt_wave : wave_ff;

	// counter and state flops; count and wave step on the shared tick, first_ff and running_ff also follow mode writes at once
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			cnt_ff     <= 16'h0000;
			first_ff   <= 1'b1;
			running_ff <= 1'b0;
			wave_ff    <= 1'b0;
		end else begin
			cnt_ff     <= nxt_cnt;
			first_ff   <= (mode_in == mode_pulse) ? (first_ff && !wrap) : 1'b1;
			running_ff <= slave && (running_ff || trig_in);
			wave_ff    <= wave_step;
		end
	end

	// period start, and end of pulse (zero-length pulse ends at its start)
	assign chain_start = wrap || (slave && trig_in);
	assign chain_out   = '{start: chain_start,
		stop: (wave_ff && !wave_step) || (chain_start && !wave_step && !wave_ff),
		period: period};
	assign wave_out    = wave_ff;

endmodule // pwm_channel

`default_nettype wire

// ===== verification/chained_pwm_pulse_timers_props.sv
/* checker for the chained timers: register port answers and wave timing;
   assumes it is bound to the top module and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
`include "timer_map.svh"

module chained_pwm_pulse_timers_props
	import timer_pkg::*;
#(
	parameter int TICK_CYCLES = 4
)(
	input wire logic       clock_in,
	input wire logic       rst_in,
	input wire reg_req_t   req_in,
	input wire logic [7:0] rdata_out,
	input wire logic       rvalid_out,
	input wire logic [2:0] high_voltage_io_out
);
	logic [15:0] gap_ff;
	logic [2:0]  hv_prev_ff;
	// cycles since the waves last changed, saturating
	always_ff @(posedge clock_in) begin
		hv_prev_ff <= high_voltage_io_out;
		if (rst_in)
			gap_ff <= 16'hffff;
		else if (high_voltage_io_out != hv_prev_ff)
			gap_ff <= 16'h0000;
		else if (gap_ff != 16'hffff)
			gap_ff <= gap_ff + 16'h0001;
	end
	// read decodes
	wire ctrl_rd = req_in.rd && (req_in.addr == `MASTER_CTRL_OFS || req_in.addr == `SECOND_CTRL_OFS
		|| req_in.addr == `THIRD_CTRL_OFS);
	wire unmap_rd = req_in.rd && (req_in.addr < `MASTER_CTRL_OFS || req_in.addr > `THIRD_DUTY_OFS);
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (rst_in);
	sequence duty_write;
		req_in.wr && req_in.addr == `MASTER_DUTY_OFS;
	endsequence
	sequence duty_read;
		!req_in.wr ##1 req_in.rd && !req_in.wr && req_in.addr == `MASTER_DUTY_OFS;
	endsequence
	// checks
	chk_read_answer: assert property (req_in.rd |=> rvalid_out) else $error("read not answered");
	chk_no_stray: assert property (!req_in.rd |=> !rvalid_out) else $error("stray read valid");
	chk_idle_rdata: assert property (!rvalid_out |-> rdata_out == 8'h00) else $error("idle rdata");
	chk_reserved_zero: assert property (ctrl_rd |=> rdata_out[7:6] == 2'h0) else $error("reserved set");
	chk_master_bit_one: assert property (req_in.rd && req_in.addr == `MASTER_CTRL_OFS |=> !rdata_out[1])
		else $error("master bit one set");
	chk_unmapped_zero: assert property (unmap_rd |=> rdata_out == 8'h00) else $error("unmapped data");
	chk_duty_back: assert property (duty_write ##1 duty_read |=> rdata_out == $past(req_in.wdata, 3))
		else $error("duty readback");
	chk_wave_tick: assert property ($changed(high_voltage_io_out) |-> gap_ff >= TICK_CYCLES - 1)
		else $error("wave off tick");
	chk_reset_quiet: assert property ($fell(rst_in) |-> high_voltage_io_out == 3'h0 && !rvalid_out)
		else $error("outputs after reset");
endmodule // chained_pwm_pulse_timers_props

bind chained_pwm_pulse_timers chained_pwm_pulse_timers_props #(.TICK_CYCLES(TICK_CYCLES)) props_i (
	.clock_in(clock_in), .rst_in(rst_in), .req_in(req_in), .rdata_out(rdata_out),
	.rvalid_out(rvalid_out), .high_voltage_io_out(high_voltage_io_out));
`default_nettype wire

// ===== verification/hv_driver_model.sv
/* model of the three output drivers: stamps rise, pulse width and period;
   assumes waves are sampled on the block clock. */
`timescale 1ns/1ps
`default_nettype none

module hv_driver_model (
	input  wire logic             clock_in,
	input  wire logic [2:0]       drive_in,
	output logic      [2:0][31:0] rise_out,
	output logic      [2:0][31:0] width_out,
	output logic      [2:0][31:0] per_out
);
	logic [31:0] cyc_ff = '0;
	logic [2:0]  last_ff = '0;
	initial begin
		rise_out = '0;
		width_out = '0;
		per_out = '0;
	end
	// stamp each driver edge in clock cycles
	always @(posedge clock_in) begin
		cyc_ff <= cyc_ff + 32'd1;
		last_ff <= drive_in;
		for (int i = 0; i < 3; i++) begin
			if (drive_in[i] && !last_ff[i]) begin
				per_out[i] <= cyc_ff - rise_out[i];
				rise_out[i] <= cyc_ff;
			end
			if (!drive_in[i] && last_ff[i])
				width_out[i] <= cyc_ff - rise_out[i];
		end
	end
endmodule // hv_driver_model
`default_nettype wire

// ===== verification/chained_pwm_pulse_timers_tb.sv
/* self-checking bench: register map, then each timer mode measured at the
   driver model; assumes tick of 4 clocks, so a 4 ms period is 160 clocks. */
`timescale 1ns/1ps
`default_nettype none
`include "timer_map.svh"

module chained_pwm_pulse_timers_tb
	import timer_pkg::*;
;
	logic             clock_in = 1'b0;
	logic             rst_in;
	reg_req_t         req_in;
	logic [7:0]       rdata_out;
	logic             rvalid_out;
	logic [2:0]       hv;
	logic [2:0][31:0] rise, width, per;
	logic [1:0]       seen;
	int               num_errors = 0;
	int               compares = 0;
	logic [7:0]       exp_tab [7] = '{8'h3d, 8'hff, 8'h3f, 8'hff, 8'h3f, 8'hff, 8'h00};

	always #4 clock_in = ~clock_in;
	chained_pwm_pulse_timers #(.TICK_CYCLES(4)) dut (.clock_in(clock_in), .rst_in(rst_in), .req_in(req_in),
		.rdata_out(rdata_out), .rvalid_out(rvalid_out), .high_voltage_io_out(hv));
	hv_driver_model drivers (.clock_in(clock_in), .drive_in(hv), .rise_out(rise), .width_out(width),
		.per_out(per));

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		@(posedge clock_in) #1 req_in = '{1'b1, 1'b0, a, d};
		@(posedge clock_in) #1 req_in = '0;
	endtask
	task automatic rd(input logic [6:0] a, input logic [7:0] exp);
		@(posedge clock_in) #1 req_in = '{1'b0, 1'b1, a, 8'h00};
		@(posedge clock_in) #1 req_in = '0;
		check({31'h0, rvalid_out}, 32'h1);
		check({24'h0, rdata_out}, {24'h0, exp});
	endtask
	// any-high / any-low of one wave over n cycles
	task automatic watch(input int n, input int b);
		seen = 2'b00;
		repeat (n) @(posedge clock_in) #1 seen = seen | (hv[b] ? 2'b10 : 2'b01);
	endtask
	function automatic logic [31:0] ph(input logic [31:0] a, input logic [31:0] b);
		return (a + 32'd1600000 - b) % 32'd160;
	endfunction
	task automatic reset_dut;
		rst_in = 1'b1;
		req_in = '0;
		repeat (6) @(posedge clock_in);
		#1 rst_in = 1'b0;
	endtask
	task automatic end_of_test;
		$display("num_errors=%0d compares=%0d", num_errors, compares);
		if (num_errors == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// main sequence
	initial begin
		reset_dut();
		for (int i = 0; i < 7; i++) rd(`MASTER_CTRL_OFS + 7'(i), 8'h00);
		for (int i = 0; i < 7; i++) begin
			wr(`MASTER_CTRL_OFS + 7'(i), 8'hff);
			rd(`MASTER_CTRL_OFS + 7'(i), exp_tab[i]);
		end
		reset_dut();
		wr(`MASTER_CTRL_OFS, 8'h01);
		wr(`MASTER_DUTY_OFS, 8'h05);
		watch(150, 0);
		check({30'h0, seen}, 32'h1);
		wr(`SECOND_CTRL_OFS, 8'h02);
		wr(`SECOND_DUTY_OFS, 8'h03);
		wr(`THIRD_CTRL_OFS, 8'h03);
		wr(`THIRD_DUTY_OFS, 8'h02);
		repeat (800) @(posedge clock_in);
		check(width[0], 32'd20);
		check(per[0], 32'd160);
		check(width[1], 32'd12);
		check(ph(rise[1], rise[0]), 32'd0);
		check(per[1], 32'd160);
		check(width[2], 32'd8);
		check(ph(rise[2], rise[1]), 32'd12);
		wr(`MASTER_CTRL_OFS, 8'h00);
		wr(`MASTER_DUTY_OFS, 8'h80);
		wr(`SECOND_CTRL_OFS, 8'h03);
		wr(`SECOND_DUTY_OFS, 8'h01);
		wr(`THIRD_CTRL_OFS, 8'h02);
		repeat (800) @(posedge clock_in);
		check(width[0], 32'd84);
		check(ph(rise[1], rise[0]), 32'd84);
		check(width[1], 32'd4);
		check(ph(rise[2], rise[0]), 32'd0);
		check(width[2], 32'd8);
		wr(`MASTER_DUTY_OFS, 8'h00);
		wr(`SECOND_CTRL_OFS, 8'h02);
		wr(`THIRD_CTRL_OFS, 8'h04);
		wr(`THIRD_DUTY_OFS, 8'h80);
		repeat (1100) @(posedge clock_in);
		check(per[1], 32'd160);
		check(width[2], 32'd164);
		check(per[2], 32'd320);
		wr(`MASTER_CTRL_OFS, 8'h01);
		wr(`MASTER_DUTY_OFS, 8'hff);
		wr(`SECOND_CTRL_OFS, 8'h01);
		wr(`SECOND_DUTY_OFS, 8'h03);
		repeat (500) @(posedge clock_in);
		watch(200, 0);
		check({30'h0, seen}, 32'h2);
		check(width[1], 32'd12);
		check(per[1], 32'd160);
		end_of_test();
	end
endmodule // chained_pwm_pulse_timers_tb
`default_nettype wire
